// *** logic/cnrxp_defines.svh ***
// register offsets, field positions and reset values of the receive pin and identifier block
`ifndef CNRXP_DEFINES_SVH
`define CNRXP_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define CNRXP_ADDR_PIN_CTRL     8'h0c
`define CNRXP_ADDR_RX0_STD_HI   8'h61
`define CNRXP_ADDR_RX0_STD_LO   8'h62
`define CNRXP_ADDR_RX0_EXT_HI   8'h63
`define CNRXP_ADDR_RX1_STD_HI   8'h71
`define CNRXP_ADDR_RX1_STD_LO   8'h72
`define CNRXP_ADDR_RX1_EXT_HI   8'h73
`define CNRXP_ADDR_IRQ_STATUS   8'h0e
`define CNRXP_ADDR_IRQ_MASK     8'h0f

// ************************************************************
// pin control fields
// ************************************************************
`define CNRXP_PC_B0_MODE        0
`define CNRXP_PC_B1_MODE        1
`define CNRXP_PC_B0_EN          2
`define CNRXP_PC_B1_EN          3
`define CNRXP_PC_B0_LEVEL       4
`define CNRXP_PC_B1_LEVEL       5
`define CNRXP_PC_WMASK          8'h3f
`define CNRXP_PC_RESET          8'h00

// ************************************************************
// identifier low fields
// ************************************************************
`define CNRXP_STDLO_ID_LSB      5
`define CNRXP_STDLO_REMOTE      4
`define CNRXP_STDLO_EXT_FLAG    3
`define CNRXP_STDLO_EXT_LSB     0

// ************************************************************
// interrupt status bits
// ************************************************************
`define CNRXP_IRQ_BUF0          0
`define CNRXP_IRQ_BUF1          1
`define CNRXP_IRQ_WMASK         8'h03
`define CNRXP_IRQ_RESET         8'h00

`endif

// *** logic/cnrxp_pkg.sv ***
// types shared by the receive pin and identifier block
`default_nettype none
package cnrxp_pkg;

  typedef struct packed {
    logic [10:0] std_id;
    logic        std_rtr;
    logic        ext_frame;
    logic [17:0] ext_id;
  } cnrxp_msg_type;

  typedef struct packed {
    logic [7:0] std_id_high;
    logic [7:0] std_id_low;
    logic [7:0] ext_id_high;
  } cnrxp_idregs_type;

endpackage
`default_nettype wire

// *** logic/cnrxp_buf_if.sv ***
// carrier between the top and one receive buffer identifier store
`timescale 1ns/100ps
`default_nettype none
interface cnrxp_buf_if;
  logic                      load;
  cnrxp_pkg::cnrxp_msg_type  msg;
  cnrxp_pkg::cnrxp_idregs_type regs;

  modport ctrl (output load, output msg, input regs);
  modport store (input load, input msg, output regs);
endinterface
`default_nettype wire

// *** logic/cnrxp_id_store.sv ***
// identifier registers of one receive buffer
`timescale 1ns/100ps
`default_nettype none
`include "cnrxp_defines.svh"
module cnrxp_id_store (
  input  wire logic   clk_sys,
  cnrxp_buf_if.store  bus
);

  typedef struct packed {
    cnrxp_pkg::cnrxp_idregs_type regs;
  } cnrxp_store_type;

  cnrxp_store_type state_reg;
  cnrxp_store_type state_next;

  // no reset: contents are undefined until the first message lands
  always_comb begin
    state_next = state_reg;
    if (bus.load) begin  // R11
      state_next.regs.std_id_high = bus.msg.std_id[10:3];  // R5
      state_next.regs.std_id_low  = 8'h00;  // R6
      state_next.regs.std_id_low[`CNRXP_STDLO_ID_LSB +: 3] = bus.msg.std_id[2:0];  // R6
      state_next.regs.std_id_low[`CNRXP_STDLO_REMOTE] = bus.msg.std_rtr & ~bus.msg.ext_frame;  // R7
      state_next.regs.std_id_low[`CNRXP_STDLO_EXT_FLAG] = bus.msg.ext_frame;  // R8
      state_next.regs.std_id_low[`CNRXP_STDLO_EXT_LSB +: 2] = bus.msg.ext_id[17:16];  // R9
      state_next.regs.ext_id_high = bus.msg.ext_id[15:8];  // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  assign bus.regs = state_reg.regs;

endmodule // cnrxp_id_store
`default_nettype wire

// *** logic/cnrxp_top.sv ***
// receive buffer full pins, identifier registers and interrupt logic
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cnrxp_defines.svh"

// Behaviour
// R1: pin level bit drives pin in output mode; reads zero in interrupt mode.
// R2: enable clear puts the pin in high impedance; set lets mode act.
// R3: mode one gives interrupt on buffer load; mode zero gives digital output.
// R4: separate read-only identifier registers per buffer at 61h-63h and 71h-73h.
// R5: identifier high holds standard identifier bits ten to three.
// R6: identifier low bits seven to five hold standard bits two to zero; bit two zero.
// R7: identifier low bit four flags a standard remote request frame.
// R8: identifier low bit three flags an extended frame.
// R9: identifier low bits one and zero hold extended bits seventeen and sixteen.
// R10: extended high register holds extended bits fifteen to eight.
// R11: identifier registers update when an accepted message loads the buffer.
module cnrxp_top (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [7:0]               reg_rdata,
  input  wire logic                     buf0_load,
  input  wire cnrxp_pkg::cnrxp_msg_type buf0_msg,
  input  wire logic                     buf1_load,
  input  wire cnrxp_pkg::cnrxp_msg_type buf1_msg,
  input  wire logic                     buf0_irq_clear,
  input  wire logic                     buf1_irq_clear,
  output var  logic                     buf0_full_pin_o,
  output var  logic                     buf0_full_pin_oe_n,
  output var  logic                     buf1_full_pin_o,
  output var  logic                     buf1_full_pin_oe_n,
  output var  logic                     irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] pin_ctrl;
    logic [1:0] pin_flag;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic       pin0_o;
    logic       pin0_oe_n;
    logic       pin1_o;
    logic       pin1_oe_n;
    logic       irq;
  } cnrxp_state_type;

  cnrxp_state_type state_reg;
  cnrxp_state_type state_next;

  cnrxp_buf_if buf0_if ();
  cnrxp_buf_if buf1_if ();

  assign buf0_if.load = buf0_load;  // R11
  assign buf0_if.msg  = buf0_msg;
  assign buf1_if.load = buf1_load;  // R11
  assign buf1_if.msg  = buf1_msg;

  // ************************************************************
  // identifier stores, one per buffer
  // ************************************************************
  cnrxp_id_store u_store0 (
    .clk_sys (clk_sys),
    .bus     (buf0_if.store)
  );  // R4

  cnrxp_id_store u_store1 (
    .clk_sys (clk_sys),
    .bus     (buf1_if.store)
  );  // R4

  // ************************************************************
  // helpers
  // ************************************************************
  // pin control as software sees it: level bits masked in interrupt mode
  function automatic logic [7:0] pc_view(input logic [7:0] pc);
    logic [7:0] v;
    v = pc;
    if (pc[`CNRXP_PC_B0_MODE]) begin
      v[`CNRXP_PC_B0_LEVEL] = 1'b0;  // R1
    end
    if (pc[`CNRXP_PC_B1_MODE]) begin
      v[`CNRXP_PC_B1_LEVEL] = 1'b0;  // R1
    end
    return v;
  endfunction

  // pin drive: returns {oe_n, level}; the pin is active low in interrupt mode
  function automatic logic [1:0] pin_drive(input logic en, input logic mode,
                                           input logic lvl, input logic flag);
    logic [1:0] d;
    d = 2'b10;
    if (!en) begin
      d = 2'b10;  // R2
    end else if (mode) begin
      d = {1'b0, ~flag};  // R3
    end else begin
      d = {1'b0, lvl};  // R1 R3
    end
    return d;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [1:0] d0;
    logic [1:0] d1;
    logic [1:0] ev;
    logic [7:0] w1c;
    d0  = 2'b00;
    d1  = 2'b00;
    ev  = 2'b00;
    w1c = 8'h00;
    state_next = state_reg;
    state_next.rdata = 8'h00;

    ev[`CNRXP_IRQ_BUF0] = buf0_load;
    ev[`CNRXP_IRQ_BUF1] = buf1_load;

    if (reg_wr) begin
      unique case (reg_addr)
        `CNRXP_ADDR_PIN_CTRL: begin
          state_next.pin_ctrl = reg_wdata & `CNRXP_PC_WMASK;
        end
        `CNRXP_ADDR_IRQ_MASK: begin
          state_next.irq_mask = reg_wdata & `CNRXP_IRQ_WMASK;
        end
        `CNRXP_ADDR_IRQ_STATUS: begin
          w1c = reg_wdata & `CNRXP_IRQ_WMASK;
        end
        default: begin
          // identifier registers are read-only; other writes are ignored
        end
      endcase
    end

    // set wins over a clear in the same cycle
    state_next.irq_status = (state_reg.irq_status & ~w1c) | {6'h00, ev};

    // buffer-full flag behind each interrupt-mode pin; the host frees the
    // buffer with the clear strobe, a new load in that cycle wins
    state_next.pin_flag[0] = buf0_load | (state_reg.pin_flag[0] & ~buf0_irq_clear);  // R3
    state_next.pin_flag[1] = buf1_load | (state_reg.pin_flag[1] & ~buf1_irq_clear);  // R3

    if (reg_rd) begin
      unique case (reg_addr)
        `CNRXP_ADDR_PIN_CTRL:   state_next.rdata = pc_view(state_reg.pin_ctrl);  // R1
        `CNRXP_ADDR_RX0_STD_HI: state_next.rdata = buf0_if.regs.std_id_high;  // R4 R5
        `CNRXP_ADDR_RX0_STD_LO: state_next.rdata = buf0_if.regs.std_id_low;  // R4 R6
        `CNRXP_ADDR_RX0_EXT_HI: state_next.rdata = buf0_if.regs.ext_id_high;  // R4 R10
        `CNRXP_ADDR_RX1_STD_HI: state_next.rdata = buf1_if.regs.std_id_high;  // R4 R5
        `CNRXP_ADDR_RX1_STD_LO: state_next.rdata = buf1_if.regs.std_id_low;  // R4 R6
        `CNRXP_ADDR_RX1_EXT_HI: state_next.rdata = buf1_if.regs.ext_id_high;  // R4 R10
        `CNRXP_ADDR_IRQ_STATUS: state_next.rdata = state_reg.irq_status;
        `CNRXP_ADDR_IRQ_MASK:   state_next.rdata = state_reg.irq_mask;
        default:                state_next.rdata = 8'h00;
      endcase
    end

    d0 = pin_drive(state_next.pin_ctrl[`CNRXP_PC_B0_EN], state_next.pin_ctrl[`CNRXP_PC_B0_MODE],
                   state_next.pin_ctrl[`CNRXP_PC_B0_LEVEL], state_next.pin_flag[0]);  // R2
    d1 = pin_drive(state_next.pin_ctrl[`CNRXP_PC_B1_EN], state_next.pin_ctrl[`CNRXP_PC_B1_MODE],
                   state_next.pin_ctrl[`CNRXP_PC_B1_LEVEL], state_next.pin_flag[1]);  // R2
    state_next.pin0_oe_n = d0[1];
    state_next.pin0_o    = d0[0];
    state_next.pin1_oe_n = d1[1];
    state_next.pin1_o    = d1[0];

    state_next.irq = |(state_next.irq_status & state_next.irq_mask);

    if (sys_rst) begin
      state_next            = '0;
      state_next.pin_ctrl   = `CNRXP_PC_RESET;
      state_next.irq_status = `CNRXP_IRQ_RESET;
      state_next.irq_mask   = `CNRXP_IRQ_RESET;
      state_next.pin0_oe_n  = 1'b1;
      state_next.pin1_oe_n  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata          = state_reg.rdata;
  assign buf0_full_pin_o    = state_reg.pin0_o;
  assign buf0_full_pin_oe_n = state_reg.pin0_oe_n;
  assign buf1_full_pin_o    = state_reg.pin1_o;
  assign buf1_full_pin_oe_n = state_reg.pin1_oe_n;
  assign irq                = state_reg.irq;

endmodule // cnrxp_top
`default_nettype wire

// *** sim/cnrxp_properties.sv ***
// port checker of the receive pin and identifier block
`timescale 1ns/100ps
`default_nettype none
module cnrxp_properties (
  input wire logic                     clk_sys,
  input wire logic                     sys_rst,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic                     irq,
  input wire logic                     buf0_load,
  input wire logic                     buf1_load,
  input wire logic                     buf0_irq_clear,
  input wire logic                     buf1_irq_clear,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic [7:0]               reg_rdata,
  input wire cnrxp_pkg::cnrxp_msg_type buf0_msg,
  input wire cnrxp_pkg::cnrxp_msg_type buf1_msg,
  input wire logic                     buf0_full_pin_o,
  input wire logic                     buf0_full_pin_oe_n,
  input wire logic                     buf1_full_pin_o,
  input wire logic                     buf1_full_pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_wr; reg_wr && reg_addr == 8'h0c; endsequence
  sequence s_ctrl_rd; reg_rd && reg_addr == 8'h0c; endsequence
  sequence s_pin0_irq_load;
    s_ctrl_wr ##0 (reg_wdata[2] && reg_wdata[0]) ##1 (buf0_load && !buf0_irq_clear);
  endsequence
  sequence s_buf1_load_rd; buf1_load ##1 (reg_rd && reg_addr == 8'h71); endsequence
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  AST_PIN_HIZ: assert property (s_ctrl_wr ##0 !reg_wdata[2] |=> buf0_full_pin_oe_n)
    else $error("disabled pin still driven");
  AST_PIN_DRIVE: assert property (s_ctrl_wr ##0 reg_wdata[3] |=> !buf1_full_pin_oe_n)
    else $error("enabled pin not driven");
  AST_PIN_LEVEL: assert property (s_ctrl_wr ##0 (reg_wdata[2] && !reg_wdata[0])
    |=> buf0_full_pin_o == $past(reg_wdata[4]))
    else $error("output pin level differs from written level");
  AST_LEVEL_RD: assert property (s_ctrl_wr ##0 reg_wdata[1] ##1 s_ctrl_rd |=> !reg_rdata[5])
    else $error("level bit not zero in interrupt mode");
  AST_IRQ_PIN: assert property (s_pin0_irq_load
    |=> !buf0_full_pin_o && !buf0_full_pin_oe_n)
    else $error("interrupt pin not asserted after load");
  AST_SIDL_GAP: assert property (reg_rd && reg_addr inside {8'h62, 8'h72}
    |=> reg_rdata[2] == 1'b0)
    else $error("unused identifier low bit not zero");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h64 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ID_LOAD: assert property (s_buf1_load_rd
    |=> reg_rdata == $past(buf1_msg.std_id[10:3], 2))
    else $error("identifier high not taken from loaded message");
endmodule // cnrxp_properties
bind cnrxp_top cnrxp_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .irq(irq), .buf0_load(buf0_load), .buf1_load(buf1_load),
  .buf0_irq_clear(buf0_irq_clear), .buf1_irq_clear(buf1_irq_clear), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .buf0_msg(buf0_msg), .buf1_msg(buf1_msg),
  .buf0_full_pin_o(buf0_full_pin_o), .buf0_full_pin_oe_n(buf0_full_pin_oe_n),
  .buf1_full_pin_o(buf1_full_pin_o), .buf1_full_pin_oe_n(buf1_full_pin_oe_n));
`default_nettype wire

// *** sim/cnrxp_pin_host.sv ***
// host side view of one buffer full pin wire
`timescale 1ns/100ps
`default_nettype none
module cnrxp_pin_host (
  input  wire logic clk_sys,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output var  logic pin_seen
);
  logic last_reg;
  always_ff @(posedge clk_sys) if (!pin_oe_n) last_reg <= pin_o;
  // no pull on the wire: a released pin shows the inverse of its last level
  always_comb pin_seen = pin_oe_n ? ~last_reg : pin_o;
endmodule // cnrxp_pin_host
`default_nettype wire

// *** sim/tb_cnrxp_top.sv ***
// testbench of the receive pin and identifier block
`timescale 1ns/100ps
`default_nettype none
module tb_cnrxp_top;
  logic                     clk_sys = 1'b0, sys_rst = 1'b1, rd_q = 1'b0;
  logic                     reg_wr = 1'b0, reg_rd = 1'b0, buf0_load = 1'b0, buf1_load = 1'b0;
  logic                     buf0_irq_clear = 1'b0, buf1_irq_clear = 1'b0;
  logic [7:0]               reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, base;
  cnrxp_pkg::cnrxp_msg_type buf0_msg = '0, buf1_msg = '0, m;
  logic                     p0_o, p0_oe_n, p1_o, p1_oe_n, p0_seen, p1_seen, irq;
  logic [7:0]               exp_q[$];
  int                       num_errors = 0, num_checks = 0, cycles = 0;
  cnrxp_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf0_load(buf0_load),
    .buf0_msg(buf0_msg), .buf1_load(buf1_load), .buf1_msg(buf1_msg),
    .buf0_irq_clear(buf0_irq_clear), .buf1_irq_clear(buf1_irq_clear), .buf0_full_pin_o(p0_o),
    .buf0_full_pin_oe_n(p0_oe_n), .buf1_full_pin_o(p1_o), .buf1_full_pin_oe_n(p1_oe_n), .irq(irq));
  cnrxp_pin_host host0 (.clk_sys(clk_sys), .pin_o(p0_o), .pin_oe_n(p0_oe_n), .pin_seen(p0_seen));
  cnrxp_pin_host host1 (.clk_sys(clk_sys), .pin_o(p1_o), .pin_oe_n(p1_oe_n), .pin_seen(p1_seen));
  initial forever #2.5 clk_sys = ~clk_sys;
  task complete_run;
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // automatic: the driver and the read monitor may both call it at one edge
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one assignment of every strobe per edge: order wr rd load0 load1 clear0 clear1
  task strobe(input logic [5:0] s);
    {reg_wr, reg_rd, buf0_load, buf1_load, buf0_irq_clear, buf1_irq_clear} <= s;
    @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    strobe(6'h20);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    exp_q.push_back(e);
    strobe(6'h10);
  endtask
  // e holds seen0, oe0_n, seen1, oe1_n; a released pin level is not judged
  // checked at the edge itself: values launched one edge earlier still stand
  task pins(input logic [3:0] e);
    strobe(6'h00);
    check("pin0 oe_n", p0_oe_n, e[2]);
    if (!e[2]) check("pin0", p0_seen, e[3]);
    check("pin1 oe_n", p1_oe_n, e[0]);
    if (!e[0]) check("pin1", p1_seen, e[1]);
  endtask
  task irq_is(input logic e);
    strobe(6'h00);
    check("irq", irq, e);
  endtask
  always @(posedge clk_sys) begin
    if (rd_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(21652));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h0c, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    pins(4'b0101);
    // every enable and mode pairing, random levels; idle interrupt pin sits high
    for (int i = 0; i < 16; i++) begin
      v = 8'(i) | 8'((($urandom % 4) << 4));
      wr(8'h0c, v);
      rd(8'h0c, v & ~{2'b00, v[1:0], 4'h0});
      pins({v[0] | v[4], ~v[2], v[1] | v[5], ~v[3]});
    end
    for (int i = 0; i < 8; i++) begin
      m = cnrxp_pkg::cnrxp_msg_type'(31'($urandom));
      m.ext_frame = i[0];
      m.std_rtr = i[1];
      base = i[2] ? 8'h71 : 8'h61;
      if (i[2]) buf1_msg <= m;
      else buf0_msg <= m;
      strobe(i[2] ? 6'h04 : 6'h08);
      rd(base, m.std_id[10:3]);
      rd(base + 8'h01, {m.std_id[2:0], m.std_rtr & ~m.ext_frame, m.ext_frame, 1'b0,
        m.ext_id[17:16]});
      rd(base + 8'h02, m.ext_id[15:8]);
      wr(base, ~m.std_id[10:3]);
      rd(base, m.std_id[10:3]);
    end
    rd(8'h64, 8'h00);
    wr(8'h0e, 8'h03);
    strobe(6'h03);
    wr(8'h0c, 8'h0f);
    strobe(6'h08);
    pins(4'b0010);
    irq_is(1'b0);
    rd(8'h0e, 8'h01);
    wr(8'h0f, 8'h01);
    irq_is(1'b1);
    wr(8'h0e, 8'h01);
    irq_is(1'b0);
    rd(8'h0e, 8'h00);
    strobe(6'h02);
    pins(4'b1010);
    // buffer one event, then a status clear that meets a new event: the event wins
    strobe(6'h04);
    pins(4'b1000);
    reg_addr <= 8'h0e;
    reg_wdata <= 8'h02;
    strobe(6'h24);
    rd(8'h0e, 8'h02);
    wr(8'h0e, 8'h02);
    strobe(6'h01);
    pins(4'b1010);
    // mid-run reset with an interrupt pending
    strobe(6'h08);
    irq_is(1'b1);
    sys_rst <= 1'b1;
    strobe(6'h00);
    sys_rst <= 1'b0;
    rd(8'h0c, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    pins(4'b0101);
    irq_is(1'b0);
    strobe(6'h00);
    complete_run();
  end
endmodule // tb_cnrxp_top
`default_nettype wire
